/* logic/ftb_pkg.sv */
/*
 * Shared constants and types of the frame transfer buffer cycler.
 * Assumes one clock domain; imported by the engine, checker, host model and testbench.
 */
package ftb_pkg;
    // Buffer cycling policies
    typedef enum logic [1:0] {
        FTB_CYC_SYNC_TRASH = 2'h0,
        FTB_CYC_NEXT_EMPTY = 2'h1,
        FTB_CYC_ASYNC = 2'h2
    } ftb_cycle_t;
    // Engine states, Gray coded along the usual path
    typedef enum logic [1:0] {
        FTB_ST_IDLE = 2'b00,
        FTB_ST_PICK = 2'b01,
        FTB_ST_MOVE = 2'b11,
        FTB_ST_DONE = 2'b10
    } ftb_state_t;
    // Default list length (last entry is the trash buffer)
    localparam int FTB_NUM_BUF = 8;
    // Default data width of one transfer word
    localparam int FTB_DATA_W = 32;
    // Default width of line, word and frame counters
    localparam int FTB_CNT_W = 16;
    // Reset value of the buffer state bits (all empty)
    localparam logic FTB_BUF_EMPTY = 1'b0;
endpackage

/* logic/ftb_engine.sv */
/*
 * Transfer engine: moves image words from on-board frame memory to a
 * list of host frame buffers, chooses each destination buffer under a
 * cycling policy, and pulses transfer events.
 * Assumes a word stream with last-of-line and last-of-frame marks
 * from on-board memory on the same clock, and a host write port with
 * valid/ready. Host clears buffer full bits with a one-cycle strobe.
 */
// Summary of operation
// R1: Pulse start of frame on first word
// R2: Pulse end of frame on last word
// R3: Pulse end of line per written line
// R4: Pulse end of N lines every N lines of a frame
// R5: Pulse end of transfer after final frame
// R6: Host stops endless transfers with a stop
// R7: Fixed frame count ends session automatically
// R8: Sync trash: full next buffer means trash
// R9: After trash, retry next, else trash again
// R10: Next-empty: skip full next, write trash
// R11: After trash, try following, else trash again
// R12: Async: cycle all buffers ignoring state
// R13: Pulse frame lost when storing impossible
// R14: Policy chosen by setting held per session
// R15: Mark finished non-trash buffer full
`timescale 1ns/1ns
module ftb_engine
    import ftb_pkg::*;
#(
    parameter int NUM_BUF = FTB_NUM_BUF,
    parameter int DATA_W = FTB_DATA_W,
    parameter int CNT_W = FTB_CNT_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Session control
    input wire logic start,
    input wire logic stop,
    input wire ftb_cycle_t cycle_mode,
    input wire logic [CNT_W-1:0] frame_count,
    input wire logic [CNT_W-1:0] nlines_count,
    // Host buffer state
    input wire logic [NUM_BUF-1:0] buf_clear,
    output logic [NUM_BUF-1:0] buf_full,
    // On-board memory stream
    input wire logic src_valid,
    output logic src_ready,
    input wire logic [DATA_W-1:0] src_data,
    input wire logic src_eol,
    input wire logic src_eof,
    input wire logic acq_frame_drop,
    // Host memory write port
    output logic dst_valid,
    input wire logic dst_ready,
    output logic [DATA_W-1:0] dst_data,
    output logic [$clog2(NUM_BUF)-1:0] dst_buf,
    output logic [CNT_W-1:0] dst_word,
    // Transfer events as one-cycle pulses, and the session busy level
    output logic ev_sof,
    output logic ev_eof,
    output logic ev_eol,
    output logic ev_nlines,
    output logic ev_eot,
    output logic ev_lost,
    output logic busy
);
    localparam int IW = $clog2(NUM_BUF);
    localparam logic [IW-1:0] TRASH = IW'(NUM_BUF - 1);
    localparam logic [IW-1:0] LAST_REAL = IW'(NUM_BUF - 2);

    // Engine state
    ftb_state_t st_r, st_nxt;
    ftb_cycle_t mode_r, mode_nxt; // Policy latched per session
    logic [IW-1:0] cur_r, cur_nxt; // Buffer being written
    logic [IW-1:0] nxt_r, nxt_nxt; // Candidate for next frame
    logic [CNT_W-1:0] frm_r, frm_nxt; // Frames finished
    logic [CNT_W-1:0] frm_lim_r, frm_lim_nxt; // Zero means endless
    logic [CNT_W-1:0] lin_r, lin_nxt; // Lines toward N
    logic [CNT_W-1:0] nl_r, nl_nxt; // Latched N
    logic [CNT_W-1:0] wrd_r, wrd_nxt; // Word offset in buffer
    logic first_r, first_nxt; // Next word opens a frame
    logic stop_r, stop_nxt; // Stop pending
    logic [NUM_BUF-1:0] full_r, full_nxt;

    // Two-entry buffer in the data path
    logic [DATA_W+1:0] sk_mem [2];
    logic sk_wp_r, sk_wp_nxt;
    logic sk_rp_r, sk_rp_nxt;
    logic [1:0] sk_cnt_r, sk_cnt_nxt;
    logic sk_in_ok, sk_out_ok, sk_out_v;
    logic [DATA_W+1:0] sk_head;
    // Output registers
    logic dv_r, dv_nxt;
    logic [DATA_W-1:0] dd_r, dd_nxt;
    logic [IW-1:0] db_r, db_nxt;
    logic [CNT_W-1:0] dw_r, dw_nxt;
    logic [5:0] ev_r, ev_nxt;
    logic take, ol, of;

    // Buffer handshake terms
    always_comb begin
        sk_out_v = (sk_cnt_r != 2'h0);
        sk_head = sk_mem[sk_rp_r];
        src_ready = (sk_cnt_r != 2'h2);
        sk_in_ok = src_valid && src_ready;
        // Drain only while moving and output slot free or leaving
        take = (st_r == FTB_ST_MOVE) && sk_out_v && (!dv_r || dst_ready);
        sk_out_ok = take;
        ol = sk_head[DATA_W];
        of = sk_head[DATA_W+1];
    end

    // Buffer storage write
    always_ff @(posedge clock) begin
        if (sk_in_ok) begin
            sk_mem[sk_wp_r] <= {src_eof, src_eol, src_data};
        end
    end

    // Buffer pointers next values
    always_comb begin
        sk_wp_nxt = sk_in_ok ? ~sk_wp_r : sk_wp_r;
        sk_rp_nxt = sk_out_ok ? ~sk_rp_r : sk_rp_r;
        sk_cnt_nxt = sk_cnt_r;
        if (sk_in_ok && !sk_out_ok) begin
            sk_cnt_nxt = sk_cnt_r + 2'h1;
        end else if (!sk_in_ok && sk_out_ok) begin
            sk_cnt_nxt = sk_cnt_r - 2'h1;
        end
    end

    // Next index wrapping over the real buffers, or over all buffers with trash
    function automatic logic [IW-1:0] wrap(input logic [IW-1:0] i,
                                           input logic real_only);
        if (real_only) begin
            return (i >= LAST_REAL) ? '0 : i + 1'b1;
        end
        return (i == TRASH) ? '0 : i + 1'b1;
    endfunction

    // Engine next values
    always_comb begin
        st_nxt = st_r;
        mode_nxt = mode_r;
        cur_nxt = cur_r;
        nxt_nxt = nxt_r;
        frm_nxt = frm_r;
        frm_lim_nxt = frm_lim_r;
        lin_nxt = lin_r;
        nl_nxt = nl_r;
        wrd_nxt = wrd_r;
        first_nxt = first_r;
        stop_nxt = stop_r || (stop && st_r != FTB_ST_IDLE); // R6
        full_nxt = full_r & ~buf_clear;
        dv_nxt = dv_r && !dst_ready;
        dd_nxt = dd_r;
        db_nxt = db_r;
        dw_nxt = dw_r;
        ev_nxt = '0;
        ev_nxt[5] = acq_frame_drop; // R13
        case (st_r)
            FTB_ST_IDLE: begin
                if (start) begin
                    mode_nxt = cycle_mode; // R14
                    frm_lim_nxt = frame_count;
                    nl_nxt = nlines_count;
                    frm_nxt = '0;
                    lin_nxt = '0;
                    nxt_nxt = '0;
                    stop_nxt = 1'b0;
                    st_nxt = FTB_ST_PICK;
                end
            end
            FTB_ST_PICK: begin
                // Choose destination before the frame starts
                if (stop_r) begin
                    st_nxt = FTB_ST_DONE;
                end else begin
                    if (mode_r == FTB_CYC_ASYNC) begin
                        cur_nxt = nxt_r; // R12
                        nxt_nxt = wrap(nxt_r, 1'b0); // R12
                    end else if (full_r[nxt_r]) begin
                        cur_nxt = TRASH; // R8 R10
                        // Sync retries same; next-empty skips it
                        nxt_nxt = (mode_r == FTB_CYC_NEXT_EMPTY) ?
                            wrap(nxt_r, 1'b1) : nxt_r; // R9 R11
                    end else begin
                        cur_nxt = nxt_r; // R8 R10
                        nxt_nxt = wrap(nxt_r, 1'b1);
                    end
                    wrd_nxt = '0;
                    first_nxt = 1'b1;
                    st_nxt = FTB_ST_MOVE;
                end
            end
            FTB_ST_MOVE: begin
                if (stop_r && first_r) begin
                    // Stop before a frame began: close the session
                    st_nxt = FTB_ST_DONE; // R5
                end else if (take) begin
                    dv_nxt = 1'b1;
                    dd_nxt = sk_head[DATA_W-1:0];
                    db_nxt = cur_r;
                    dw_nxt = wrd_r;
                    wrd_nxt = wrd_r + 1'b1;
                    first_nxt = 1'b0;
                    ev_nxt[0] = first_r; // R1
                    if (ol || of) begin
                        ev_nxt[2] = 1'b1; // R3
                        if (nl_r != '0 && lin_r + 1'b1 == nl_r) begin
                            ev_nxt[3] = 1'b1; // R4
                            lin_nxt = '0;
                        end else begin
                            lin_nxt = lin_r + 1'b1;
                        end
                    end
                    if (of) begin
                        ev_nxt[1] = 1'b1; // R2
                        lin_nxt = '0;
                        frm_nxt = frm_r + 1'b1;
                        if (cur_r != TRASH) begin
                            full_nxt[cur_r] = 1'b1; // R15
                        end
                        if ((frm_lim_r != '0 &&
                             frm_r + 1'b1 == frm_lim_r) || stop_r) begin
                            st_nxt = FTB_ST_DONE; // R7
                        end else begin
                            st_nxt = FTB_ST_PICK;
                        end
                    end
                end
            end
            FTB_ST_DONE: begin
                // Wait for the last word to leave the port
                if (!dv_r) begin
                    ev_nxt[4] = 1'b1; // R5
                    st_nxt = FTB_ST_IDLE;
                end
            end
            default: begin
                st_nxt = FTB_ST_IDLE;
            end
        endcase
    end

    // Register all state except the buffer storage
    always_ff @(posedge clock) begin
        if (reset) begin
            st_r <= FTB_ST_IDLE;
            mode_r <= FTB_CYC_SYNC_TRASH;
            cur_r <= '0;
            nxt_r <= '0;
            frm_r <= '0;
            frm_lim_r <= '0;
            lin_r <= '0;
            nl_r <= '0;
            wrd_r <= '0;
            first_r <= 1'b0;
            stop_r <= 1'b0;
            full_r <= {NUM_BUF{FTB_BUF_EMPTY}};
            sk_wp_r <= 1'b0;
            sk_rp_r <= 1'b0;
            sk_cnt_r <= 2'h0;
            dv_r <= 1'b0;
            dd_r <= '0;
            db_r <= '0;
            dw_r <= '0;
            ev_r <= '0;
        end else begin
            st_r <= st_nxt;
            mode_r <= mode_nxt;
            cur_r <= cur_nxt;
            nxt_r <= nxt_nxt;
            frm_r <= frm_nxt;
            frm_lim_r <= frm_lim_nxt;
            lin_r <= lin_nxt;
            nl_r <= nl_nxt;
            wrd_r <= wrd_nxt;
            first_r <= first_nxt;
            stop_r <= stop_nxt;
            full_r <= full_nxt;
            sk_wp_r <= sk_wp_nxt;
            sk_rp_r <= sk_rp_nxt;
            sk_cnt_r <= sk_cnt_nxt;
            dv_r <= dv_nxt;
            dd_r <= dd_nxt;
            db_r <= db_nxt;
            dw_r <= dw_nxt;
            ev_r <= ev_nxt;
        end
    end

    // Outputs from registers
    assign buf_full = full_r;
    assign dst_valid = dv_r;
    assign dst_data = dd_r;
    assign dst_buf = db_r;
    assign dst_word = dw_r;
    assign ev_sof = ev_r[0];
    assign ev_eof = ev_r[1];
    assign ev_eol = ev_r[2];
    assign ev_nlines = ev_r[3];
    assign ev_eot = ev_r[4];
    assign ev_lost = ev_r[5];
    assign busy = (st_r != FTB_ST_IDLE);
endmodule

/* test/ftb_engine_assertions.sv */
/* Checker of the transfer engine's events and session flag.
   Bound to every ftb_engine; sees only its ports. */
`timescale 1ns/1ns
module ftb_engine_chk
    import ftb_pkg::*;
#(
    parameter int NUM_BUF = FTB_NUM_BUF,
    parameter int CNT_W = FTB_CNT_W
) (
    // Clock, reset and control
    input wire logic clock,
    input wire logic reset,
    input wire logic start,
    input wire logic acq_frame_drop,
    input wire logic busy,
    // Watched outputs
    input wire logic [NUM_BUF-1:0] buf_full,
    input wire logic dst_valid,
    input wire logic [CNT_W-1:0] dst_word,
    input wire logic ev_sof,
    input wire logic ev_eof,
    input wire logic ev_eol,
    input wire logic ev_nlines,
    input wire logic ev_eot,
    input wire logic ev_lost
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // Frame opens on word zero
    sequence s_word0; dst_valid && dst_word == '0; endsequence
    // Port drained, then session closes
    sequence s_close; !dst_valid ##1 !busy; endsequence
    // Pick then move, both busy
    sequence s_launch; busy ##1 busy; endsequence
    property p_sof; ev_sof |-> s_word0; endproperty
    property p_eof; ev_eof |-> ev_eol && dst_valid; endproperty
    property p_eol; ev_eol |-> dst_valid && busy; endproperty
    property p_nlines; ev_nlines |-> ev_eol; endproperty
    property p_eot; ev_eot |-> s_close; endproperty
    property p_lost; acq_frame_drop |=> ev_lost; endproperty
    property p_trash; buf_full[NUM_BUF-1] == 1'b0; endproperty
    property p_start; start && !busy |=> s_launch; endproperty
    a_sof: assert property (p_sof)
        else $error("start of frame off word zero");
    a_eof: assert property (p_eof)
        else $error("frame end without line end");
    a_eol: assert property (p_eol)
        else $error("line end without a write");
    a_nlines: assert property (p_nlines)
        else $error("line group end off a line end");
    a_eot: assert property (p_eot)
        else $error("transfer end with port busy");
    a_lost: assert property (p_lost)
        else $error("dropped frame not reported");
    a_trash: assert property (p_trash)
        else $error("trash buffer marked full");
    a_start: assert property (p_start)
        else $error("session did not start");
endmodule
bind ftb_engine ftb_engine_chk #(.NUM_BUF(NUM_BUF), .CNT_W(CNT_W)) u_chk (
    .clock, .reset, .start, .acq_frame_drop, .busy, .buf_full, .dst_valid,
    .dst_word, .ev_sof, .ev_eof, .ev_eol, .ev_nlines, .ev_eot, .ev_lost);

/* test/ftb_host_model.sv */
/* Host memory model: takes engine writes, stalls on request and
   checks that word indexes run up from zero in each buffer. */
`timescale 1ns/1ns
module ftb_host_model
    import ftb_pkg::*;
#(
    parameter int CNT_W = FTB_CNT_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Write port
    input wire logic dst_valid,
    output logic dst_ready,
    input wire logic [CNT_W-1:0] dst_word,
    // Stall control and tallies
    input wire logic slow,
    output int taken,
    output int order_errs
);
    logic [1:0] ph_r; // Stall phase
    logic [CNT_W-1:0] next_r; // Expected next index
    // Ready drops one cycle in three when slow
    always_ff @(posedge clock) begin
        ph_r <= (reset || ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
        dst_ready <= !reset && !(slow && ph_r == 2'h0);
        if (reset) begin
            taken <= 0;
            order_errs <= 0;
            next_r <= '0;
        end else if (dst_valid && dst_ready) begin
            taken <= taken + 1;
            next_r <= dst_word + 1'b1;
            if (dst_word != '0 && dst_word != next_r)
                order_errs <= order_errs + 1;
        end
    end
endmodule

/* test/test_frame_transfer_buffer_cycler.sv */
/* Testbench of the transfer engine: cycling policies, events, stop.
   Assumes the host model answers the engine's write port. */
`timescale 1ns/1ns
module test_frame_transfer_buffer_cycler
    import ftb_pkg::*;
();
    logic clock, reset, start, stop, src_valid, src_ready, src_eol, src_eof;
    logic acq_frame_drop, dst_valid, dst_ready, slow, busy;
    logic ev_sof, ev_eof, ev_eol, ev_nlines, ev_eot, ev_lost;
    ftb_cycle_t cycle_mode;
    logic [7:0] frame_count, nlines_count, dst_word;
    logic [3:0] buf_clear, buf_full;
    logic [15:0] src_data, dst_data;
    logic [1:0] dst_buf;
    logic [1:0] sofs[$]; // Buffer of each frame start
    int num_errors, tests_run, taken, order_errs, cyc;
    int n_eol, n_eof, n_nl, n_eot, n_lost, n_bad;
    logic [15:0] exp_data; // Data of the next host write
    ftb_engine #(.NUM_BUF(4), .DATA_W(16), .CNT_W(8)) dut (
        .clock, .reset, .start, .stop, .cycle_mode, .frame_count,
        .nlines_count, .buf_clear, .buf_full, .src_valid, .src_ready,
        .src_data, .src_eol, .src_eof, .acq_frame_drop, .dst_valid,
        .dst_ready, .dst_data, .dst_buf, .dst_word, .ev_sof, .ev_eof,
        .ev_eol, .ev_nlines, .ev_eot, .ev_lost, .busy);
    ftb_host_model #(.CNT_W(8)) host (.clock, .reset, .dst_valid,
        .dst_ready, .dst_word, .slow, .taken, .order_errs);
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Event tally, host data order and watchdog; tally and order cleared by reset
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (reset === 1'b1) begin
            sofs.delete();
            {n_eol, n_eof, n_nl, n_eot, n_lost, n_bad} <= '0;
            exp_data <= src_data + 16'h0001;
        end else begin
            if (ev_sof === 1'b1)
                sofs.push_back(dst_buf);
            n_eol <= n_eol + (ev_eol === 1'b1);
            n_eof <= n_eof + (ev_eof === 1'b1);
            n_nl <= n_nl + (ev_nlines === 1'b1);
            n_eot <= n_eot + (ev_eot === 1'b1);
            n_lost <= n_lost + (ev_lost === 1'b1);
            // Words reach the host in stream order
            if (dst_valid === 1'b1 && dst_ready === 1'b1) begin
                n_bad <= n_bad + (dst_data !== exp_data);
                exp_data <= exp_data + 16'h0001;
            end
        end
        if (cyc == 30000) begin
            num_errors++;
            stop_test;
        end
    end
    task check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    // One stream word, held until taken
    task word(input logic eol, input logic eof);
        src_valid = 1'b1;
        src_eol = eol;
        src_eof = eof;
        src_data = src_data + 16'h0001;
        while (src_ready !== 1'b1)
            @(negedge clock);
        @(negedge clock);
    endtask
    // Two lines of two words; host may empty a buffer mid-frame
    task frame(input int cl);
        for (int i = 0; i < 4; i++) begin
            word(i[0], i == 3);
            if (i == 0 && cl >= 0) begin
                // Hold the stream off so no extra word slips in
                src_valid = 1'b0;
                while (sofs.size() < 5)
                    @(negedge clock);
                buf_clear = 4'h1 << cl;
                @(negedge clock);
                buf_clear = 4'h0;
            end
        end
    endtask
    // Fresh reset, session start, then the frames
    task run(input ftb_cycle_t m, input int fc, input int ns, input int cl);
        reset = 1'b1;
        repeat (5) @(negedge clock);
        reset = 1'b0;
        cycle_mode = m;
        frame_count = fc[7:0];
        start = 1'b1;
        @(negedge clock);
        start = 1'b0;
        for (int f = 0; f < ns; f++)
            frame(f == 4 ? cl : -1);
        src_valid = 1'b0;
    endtask
    // Wait for idle, then judge the session
    task done(input int n, input logic [11:0] e, input logic [3:0] full);
        while (busy !== 1'b0)
            @(negedge clock);
        // End of transfer pulses with idle; let the tally see it
        @(negedge clock);
        check(sofs.size(), n);
        for (int i = 0; i < n; i++)
            check(sofs[i], e[2*i+:2]);
        check(n_eof, n);
        check(n_eol, 2 * n);
        check(n_nl, n);
        check(n_eot, 1);
        check(buf_full, full);
        check(taken, 4 * n);
        check(order_errs, 0);
        check(n_bad, 0);
    endtask
    task test_async;
        slow = 1'b0;
        run(FTB_CYC_ASYNC, 5, 5, -1);
        done(5, 12'h0E4, 4'h7);
        $display("async cycling done");
    endtask
    task test_sync;
        run(FTB_CYC_SYNC_TRASH, 6, 6, 0);
        done(6, 12'h3E4, 4'h7);
        $display("sync trash cycling done");
    endtask
    task test_next;
        slow = 1'b1;
        run(FTB_CYC_NEXT_EMPTY, 6, 6, 2);
        done(6, 12'hBE4, 4'h7);
        $display("next empty cycling done");
    endtask
    task test_stop;
        run(FTB_CYC_SYNC_TRASH, 0, 2, -1);
        acq_frame_drop = 1'b1;
        @(negedge clock);
        acq_frame_drop = 1'b0;
        stop = 1'b1;
        @(negedge clock);
        stop = 1'b0;
        done(2, 12'h004, 4'h3);
        check(n_lost, 1);
        $display("endless session stop done");
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        {start, stop, src_valid, src_eol, src_eof} = 5'h00;
        {acq_frame_drop, slow} = 2'h0;
        cycle_mode = FTB_CYC_SYNC_TRASH;
        frame_count = 8'h00;
        nlines_count = 8'h02;
        buf_clear = 4'h0;
        src_data = 16'h0000;
        test_async;
        test_sync;
        test_next;
        test_stop;
        stop_test;
    end
endmodule
